// File: lacg_pkg.sv
package lacg_pkg;
    // Register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_KSET = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h2;
    localparam int CTRL_ILA_EN = 0;
    localparam int CTRL_SCR = 1;
    localparam int CTRL_KOV = 2;
    localparam int CTRL_DUAL = 3;
    localparam int CTRL_TWOS = 4;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_SVALID = 2;
    localparam int KSET_W = 5;
    localparam logic [DATA_W-1:0] RDATA_ZERO = 8'h00;
    localparam logic [KSET_W-1:0] KSET_RESET = 5'h00;

    // Sample path
    localparam int SAMPLE_W = 14;
    localparam int LATENCY = 20;
    localparam int DELAY_DEPTH = LATENCY - 2;
    localparam int PTR_W = 5;
    localparam logic [PTR_W-1:0] PTR_LAST = 5'(DELAY_DEPTH - 1);
    localparam logic [PTR_W-1:0] FILL_FULL = 5'(LATENCY);
    localparam logic [PTR_W-1:0] PTR_ONE = 5'h01;

    // Configuration octets
    localparam int OCTET_W = 8;
    localparam int OCT_NUM_W = 4;
    localparam logic [OCT_NUM_W-1:0] OCT_DID = 4'h0;
    localparam logic [OCT_NUM_W-1:0] OCT_BID = 4'h1;
    localparam logic [OCT_NUM_W-1:0] OCT_LID = 4'h2;
    localparam logic [OCT_NUM_W-1:0] OCT_SCR_L = 4'h3;
    localparam logic [OCT_NUM_W-1:0] OCT_F = 4'h4;
    localparam logic [OCT_NUM_W-1:0] OCT_K = 4'h5;
    localparam logic [OCT_NUM_W-1:0] OCT_M = 4'h6;
    localparam logic [OCT_NUM_W-1:0] OCT_CS_N = 4'h7;
    localparam logic [OCT_NUM_W-1:0] OCT_NP = 4'h8;
    localparam logic [OCT_NUM_W-1:0] OCT_S = 4'h9;
    localparam logic [OCT_NUM_W-1:0] OCT_HD_CF = 4'ha;
    localparam logic [OCT_NUM_W-1:0] OCT_RES1 = 4'hb;
    localparam logic [OCT_NUM_W-1:0] OCT_RES2 = 4'hc;
    localparam logic [OCT_NUM_W-1:0] OCT_FCHK = 4'hd;
    localparam logic [OCT_NUM_W-1:0] OCT_ONE = 4'h1;

    localparam logic [7:0] FLD_DID = 8'h00;
    localparam logic [3:0] FLD_BID = 4'h0;
    localparam logic [7:0] FLD_M = 8'h00;
    localparam logic [1:0] FLD_CS = 2'h0;
    localparam logic [4:0] FLD_N = 5'h0d;
    localparam logic [4:0] FLD_NP = 5'h0f;
    localparam logic [4:0] FLD_S = 5'h00;
    localparam logic FLD_HD = 1'b0;
    localparam logic [4:0] FLD_CF = 5'h00;
    localparam logic [7:0] FLD_RES = 8'h00;
    localparam logic [7:0] F_SINGLE = 8'h01;
    localparam logic [7:0] F_DUAL = 8'h00;
    localparam logic [4:0] K_SINGLE = 5'h08;
    localparam logic [4:0] K_DUAL = 5'h10;
    localparam logic [4:0] L_SINGLE = 5'h00;
    localparam logic [4:0] L_DUAL = 5'h01;
    localparam logic [4:0] LID_LANE1 = 5'h00;
    localparam logic [4:0] LID_LANE2 = 5'h01;

    typedef enum logic [1:0] {
        ILA_IDLE = 2'b00,
        ILA_SEND = 2'b01,
        ILA_DONE = 2'b10
    } lacg_ila_state_t;
endpackage : lacg_pkg

// File: lacg_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lacg_cfg_if;
    import lacg_pkg::*;
    logic lane_dual;
    logic scramble_select;
    logic k_override;
    logic [KSET_W-1:0] frames_per_multiframe_setting;
    logic [OCT_NUM_W-1:0] octet_num;
    logic [OCTET_W-1:0] octet_lane1;
    logic [OCTET_W-1:0] octet_lane2;

    modport src (
        output lane_dual, scramble_select, k_override, frames_per_multiframe_setting, octet_num,
        input octet_lane1, octet_lane2
    );
    modport gen (
        input lane_dual, scramble_select, k_override, frames_per_multiframe_setting, octet_num,
        output octet_lane1, octet_lane2
    );
endinterface : lacg_cfg_if
`default_nettype wire

// File: lacg_delay_mem.sv
`timescale 1ns/1ps
`default_nettype none
module lacg_delay_mem (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Access
    input wire logic [lacg_pkg::PTR_W-1:0] addr,
    input wire logic [lacg_pkg::SAMPLE_W-1:0] wdata,
    output logic [lacg_pkg::SAMPLE_W-1:0] rdata
);
    import lacg_pkg::*;

    // Read and write share one address: the old word leaves as the new one lands
    logic [SAMPLE_W-1:0] mem [DELAY_DEPTH];
    logic [SAMPLE_W-1:0] rdata_reg;

    always_ff @(posedge core_clk) begin
        mem[addr] <= wdata;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= mem[addr];
        end
    end

    assign rdata = rdata_reg;
endmodule : lacg_delay_mem
`default_nettype wire

// File: lacg_octet_gen.sv
`timescale 1ns/1ps
`default_nettype none
module lacg_octet_gen (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Configuration and octet select
    lacg_cfg_if.gen cfg
);
    import lacg_pkg::*;

    typedef struct packed {
        logic [OCTET_W-1:0] oct1;
        logic [OCTET_W-1:0] oct2;
    } lacg_gen_state_t;

    lacg_gen_state_t st_reg;
    lacg_gen_state_t st_next;
    logic [4:0] l_fld;
    logic [7:0] f_fld;
    logic [4:0] k_fld;

    // Sum of field values, recomputed every cycle from live settings
    function automatic logic [7:0] lacg_fchk(input logic [4:0] lid, input logic [4:0] l,
                                             input logic [7:0] f, input logic [4:0] k, input logic scr);
        logic [7:0] sum;
        sum = FLD_DID + {4'h0, FLD_BID} + {3'h0, lid} + {7'h00, scr} + {3'h0, l} + f + {3'h0, k};
        sum = sum + FLD_M + {6'h00, FLD_CS} + {3'h0, FLD_N} + {3'h0, FLD_NP} + {3'h0, FLD_S};
        sum = sum + {7'h00, FLD_HD} + {3'h0, FLD_CF};
        return sum;
    endfunction : lacg_fchk

    function automatic logic [7:0] lacg_octet(input logic [OCT_NUM_W-1:0] num, input logic [4:0] lid,
                                              input logic [4:0] l, input logic [7:0] f,
                                              input logic [4:0] k, input logic scr);
        logic [7:0] o;
        o = FLD_RES;
        case (num)
            OCT_DID: o = FLD_DID;
            OCT_BID: o = {4'h0, FLD_BID};
            OCT_LID: o = {3'h0, lid};
            OCT_SCR_L: o = {scr, 2'h0, l};
            OCT_F: o = f;
            OCT_K: o = {3'h0, k};
            OCT_M: o = FLD_M;
            OCT_CS_N: o = {FLD_CS, 1'b0, FLD_N};
            OCT_NP: o = {3'h0, FLD_NP};
            OCT_S: o = {3'h0, FLD_S};
            OCT_HD_CF: o = {FLD_HD, 2'h0, FLD_CF};
            OCT_RES1: o = FLD_RES;
            OCT_RES2: o = FLD_RES;
            OCT_FCHK: o = lacg_fchk(lid, l, f, k, scr);
            default: o = FLD_RES;
        endcase
        return o;
    endfunction : lacg_octet

    always_comb begin
        l_fld = cfg.lane_dual ? L_DUAL : L_SINGLE;
        f_fld = cfg.lane_dual ? F_DUAL : F_SINGLE;
        if (cfg.k_override) begin
            k_fld = cfg.frames_per_multiframe_setting;
        end else if (cfg.lane_dual) begin
            k_fld = K_DUAL;
        end else begin
            k_fld = K_SINGLE;
        end
        st_next.oct1 = lacg_octet(cfg.octet_num, LID_LANE1, l_fld, f_fld, k_fld, cfg.scramble_select);
        st_next.oct2 = lacg_octet(cfg.octet_num, LID_LANE2, l_fld, f_fld, k_fld, cfg.scramble_select);
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cfg.octet_lane1 = st_reg.oct1;
    assign cfg.octet_lane2 = st_reg.oct2;
endmodule : lacg_octet_gen
`default_nettype wire

// File: lacg_top.sv
`timescale 1ns/1ps
`default_nettype none
module lacg_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Register port
    input wire logic [lacg_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [lacg_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [lacg_pkg::DATA_W-1:0] reg_rdata,
    // Converter core samples
    input wire logic [lacg_pkg::SAMPLE_W-1:0] conv_data_in,
    output logic [lacg_pkg::SAMPLE_W-1:0] sample_out,
    output logic sample_out_valid,
    // Lane alignment octets
    output logic ila_valid,
    output logic [lacg_pkg::OCT_NUM_W-1:0] ila_octet_num,
    output logic [lacg_pkg::OCTET_W-1:0] ila_lane1_octet,
    output logic [lacg_pkg::OCTET_W-1:0] ila_lane2_octet,
    output logic ila_lane2_active
);
    import lacg_pkg::*;

    typedef struct packed {
        logic ila_en;
        logic scr;
        logic kov;
        logic dual;
        logic twos;
        logic [KSET_W-1:0] kset;
        lacg_ila_state_t ila_state;
        logic [OCT_NUM_W-1:0] oct_cnt;
        logic ila_done;
        logic ila_vld;
        logic [OCT_NUM_W-1:0] ila_num;
        logic [SAMPLE_W-1:0] sample;
        logic [PTR_W-1:0] wptr;
        logic [PTR_W-1:0] fill;
        logic [SAMPLE_W-1:0] sout;
        logic svalid;
        logic [DATA_W-1:0] rdata;
    } lacg_top_state_t;

    lacg_top_state_t st_reg;
    lacg_top_state_t st_next;
    logic [SAMPLE_W-1:0] mem_rdata;
    logic send_act;

    lacg_cfg_if cfg_bus ();

    lacg_octet_gen u_gen (
        .core_clk(core_clk),
        .nrst(nrst),
        .cfg(cfg_bus.gen)
    );

    lacg_delay_mem u_mem (
        .core_clk(core_clk),
        .nrst(nrst),
        .addr(st_reg.wptr),
        .wdata(st_reg.sample),
        .rdata(mem_rdata)
    );

    assign cfg_bus.lane_dual = st_reg.dual;
    assign cfg_bus.scramble_select = st_reg.scr;
    assign cfg_bus.k_override = st_reg.kov;
    assign cfg_bus.frames_per_multiframe_setting = st_reg.kset;
    assign cfg_bus.octet_num = st_reg.oct_cnt;

    always_comb begin
        st_next = st_reg;
        send_act = 1'b0;

        // Register writes
        if (reg_wr) begin
            if (reg_addr == ADDR_CTRL) begin
                st_next.ila_en = reg_wdata[CTRL_ILA_EN];
                st_next.scr = reg_wdata[CTRL_SCR];
                st_next.kov = reg_wdata[CTRL_KOV];
                st_next.dual = reg_wdata[CTRL_DUAL];
                st_next.twos = reg_wdata[CTRL_TWOS];
            end else if (reg_addr == ADDR_KSET) begin
                st_next.kset = reg_wdata[KSET_W-1:0];
            end else if (reg_addr == ADDR_STATUS) begin
                if (reg_wdata[STAT_DONE]) begin
                    st_next.ila_done = 1'b0;
                end
            end
        end

        // Read data stand for exactly one cycle
        st_next.rdata = RDATA_ZERO;
        if (reg_rd) begin
            if (reg_addr == ADDR_CTRL) begin
                st_next.rdata[CTRL_ILA_EN] = st_reg.ila_en;
                st_next.rdata[CTRL_SCR] = st_reg.scr;
                st_next.rdata[CTRL_KOV] = st_reg.kov;
                st_next.rdata[CTRL_DUAL] = st_reg.dual;
                st_next.rdata[CTRL_TWOS] = st_reg.twos;
            end else if (reg_addr == ADDR_KSET) begin
                st_next.rdata[KSET_W-1:0] = st_reg.kset;
            end else if (reg_addr == ADDR_STATUS) begin
                st_next.rdata[STAT_BUSY] = (st_reg.ila_state == ILA_SEND);
                st_next.rdata[STAT_DONE] = st_reg.ila_done;
                st_next.rdata[STAT_SVALID] = st_reg.svalid;
            end
        end

        // One pass per enable; enable must drop before another pass can start
        case (st_reg.ila_state)
            ILA_IDLE: begin
                st_next.oct_cnt = OCT_DID;
                if (st_reg.ila_en) begin
                    st_next.ila_state = ILA_SEND;
                end
            end
            ILA_SEND: begin
                send_act = 1'b1;
                if (st_reg.oct_cnt == OCT_FCHK) begin
                    st_next.ila_state = ILA_DONE;
                    st_next.oct_cnt = OCT_DID;
                    st_next.ila_done = 1'b1;
                end else begin
                    st_next.oct_cnt = st_reg.oct_cnt + OCT_ONE;
                end
            end
            ILA_DONE: begin
                st_next.oct_cnt = OCT_DID;
                if (!st_reg.ila_en) begin
                    st_next.ila_state = ILA_IDLE;
                end
            end
            default: begin
                st_next.ila_state = ILA_IDLE;
                st_next.oct_cnt = OCT_DID;
            end
        endcase

        // Octets come out of the generator one cycle behind the select
        st_next.ila_vld = send_act;
        st_next.ila_num = st_reg.oct_cnt;

        // Sample taken on this edge, then a fixed-depth ring sets the latency
        st_next.sample = conv_data_in;
        if (st_reg.wptr == PTR_LAST) begin
            st_next.wptr = '0;
        end else begin
            st_next.wptr = st_reg.wptr + PTR_ONE;
        end
        if (st_reg.fill != FILL_FULL) begin
            st_next.fill = st_reg.fill + PTR_ONE;
        end
        st_next.svalid = st_reg.svalid | (st_reg.fill == FILL_FULL);
        if (st_reg.twos) begin
            st_next.sout = {~mem_rdata[SAMPLE_W-1], mem_rdata[SAMPLE_W-2:0]};
        end else begin
            st_next.sout = mem_rdata;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '{ila_state: ILA_IDLE, kset: KSET_RESET, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign sample_out = st_reg.sout;
    assign sample_out_valid = st_reg.svalid;
    assign ila_valid = st_reg.ila_vld;
    assign ila_octet_num = st_reg.ila_num;
    assign ila_lane1_octet = cfg_bus.octet_lane1;
    assign ila_lane2_octet = cfg_bus.octet_lane2;
    assign ila_lane2_active = st_reg.dual;
endmodule : lacg_top
`default_nettype wire

// File: lacg_dummy_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: lacg_ila_rx.sv
`timescale 1ns/1ps
`default_nettype none
module lacg_ila_rx (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Alignment octets from the transmitter
    input wire logic ila_valid,
    input wire logic [lacg_pkg::OCT_NUM_W-1:0] ila_octet_num,
    input wire logic [lacg_pkg::OCTET_W-1:0] ila_lane1_octet,
    input wire logic [lacg_pkg::OCTET_W-1:0] ila_lane2_octet,
    input wire logic ila_lane2_active,
    // Count of captured octets
    output logic [7:0] rx_count
);
    import lacg_pkg::*;
    logic [7:0] oct1 [14];
    logic [7:0] oct2 [14];
    // Octets land by number, so a wrong order shows as a wrong field
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rx_count <= 8'h00;
        end else if (ila_valid) begin
            rx_count <= rx_count + 8'h01;
            oct1[ila_octet_num] <= ila_lane1_octet;
            oct2[ila_octet_num] <= ila_lane2_active ? ila_lane2_octet : 8'hxx;
        end
    end
endmodule : lacg_ila_rx
`default_nettype wire

// File: lacg_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
module lacg_top_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Register port
    input wire logic [lacg_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [lacg_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    // Samples
    input wire logic [lacg_pkg::SAMPLE_W-1:0] conv_data_in,
    input wire logic [lacg_pkg::SAMPLE_W-1:0] sample_out,
    input wire logic sample_out_valid,
    // Octets
    input wire logic ila_valid,
    input wire logic [lacg_pkg::OCT_NUM_W-1:0] ila_octet_num,
    input wire logic [lacg_pkg::OCTET_W-1:0] ila_lane1_octet,
    input wire logic [lacg_pkg::OCTET_W-1:0] ila_lane2_octet,
    input wire logic ila_lane2_active
);
    import lacg_pkg::*;
    logic [7:0] ctrl_sh;
    logic [4:0] kset_sh;
    logic [4:0] k_exp;
    logic v_at;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_sh <= 8'h00;
            kset_sh <= 5'h00;
        end else if (reg_wr && reg_addr == ADDR_CTRL) begin
            ctrl_sh <= reg_wdata;
        end else if (reg_wr && reg_addr == ADDR_KSET) begin
            kset_sh <= reg_wdata[4:0];
        end
    end
    assign k_exp = ctrl_sh[CTRL_KOV] ? kset_sh : (ctrl_sh[CTRL_DUAL] ? 5'h10 : 5'h08);
    assign v_at = ila_valid && !ila_lane2_active;
    a_ila_needs_enable: assert property ($rose(ila_valid) |-> ctrl_sh[CTRL_ILA_EN])
        else $error("alignment octets without enable");
    a_octet_start: assert property ($rose(ila_valid) |-> ila_octet_num == 4'h0)
        else $error("pass does not start at octet 0");
    a_octet_step: assert property (ila_valid && ila_octet_num != 4'hd |=> ila_valid && ila_octet_num == $past(ila_octet_num) + 4'h1)
        else $error("octet number skipped");
    a_pass_end: assert property (ila_valid && ila_octet_num == 4'hd |=> !ila_valid)
        else $error("pass runs past checksum");
    a_f_field: assert property (ila_valid && ila_octet_num == 4'h4 |-> ila_lane1_octet == (ila_lane2_active ? 8'h00 : 8'h01))
        else $error("frame field wrong");
    a_lane_ids: assert property (ila_valid && ila_octet_num == 4'h2 |-> ila_lane1_octet == 8'h00 && (!ila_lane2_active || ila_lane2_octet == 8'h01))
        else $error("lane id wrong");
    a_k_field: assert property (ila_valid && ila_octet_num == 4'h5 |-> ila_lane1_octet == {3'b000, k_exp})
        else $error("multiframe field wrong");
    a_reserved_zero: assert property (ila_valid && (ila_octet_num == 4'hb || ila_octet_num == 4'hc) |-> ila_lane1_octet == 8'h00 && (!ila_lane2_active || ila_lane2_octet == 8'h00))
        else $error("reserved octet not zero");
    a_scr_lanes: assert property (ila_valid && ila_octet_num == 4'h3 |-> ila_lane1_octet == {ctrl_sh[CTRL_SCR], 6'h00, ila_lane2_active})
        else $error("scramble or lane count wrong");
    a_checksum: assert property (ila_valid && ila_octet_num == 4'hd |-> ila_lane1_octet == 8'(8'd29 + ctrl_sh[CTRL_SCR] + k_exp))
        else $error("checksum wrong");
    a_sample_delay: assert property (sample_out_valid |-> sample_out == {$past(conv_data_in[13], 21) ^ $past(ctrl_sh[CTRL_TWOS]), $past(conv_data_in[12:0], 21)})
        else $error("sample latency wrong");
    c_single_pass: cover property (v_at && ila_octet_num == 4'hd);
    c_dual_pass: cover property (ila_valid && ila_lane2_active && ila_octet_num == 4'hd);
    c_samples: cover property ($rose(sample_out_valid));
endmodule : lacg_top_checker
bind lacg_top lacg_top_checker u_lacg_top_checker (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .conv_data_in(conv_data_in), .sample_out(sample_out),
    .sample_out_valid(sample_out_valid), .ila_valid(ila_valid), .ila_octet_num(ila_octet_num),
    .ila_lane1_octet(ila_lane1_octet), .ila_lane2_octet(ila_lane2_octet), .ila_lane2_active(ila_lane2_active));
`default_nettype wire

// File: lacg_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; $display("mismatch at %0t: got %h exp %h", $time, a, b); end end
module tb;
    import lacg_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [13:0] conv_data_in = 14'h0000;
    logic [13:0] sample_out;
    logic sample_out_valid, ila_valid, ila_lane2_active;
    logic [3:0] ila_octet_num;
    logic [7:0] ila_lane1_octet, ila_lane2_octet, rx_count;
    logic [13:0] hist [$];
    int n_fail = 0;
    int n_compared = 0;
    always #50 core_clk = ~core_clk;
    // Ramp with a moving top bit so the format flip is visible
    always @(posedge core_clk) begin
        hist.push_back(conv_data_in);
        conv_data_in <= conv_data_in + 14'h0a5b;
    end
    lacg_top u_lacg_top (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_data_in(conv_data_in),
        .sample_out(sample_out), .sample_out_valid(sample_out_valid), .ila_valid(ila_valid),
        .ila_octet_num(ila_octet_num), .ila_lane1_octet(ila_lane1_octet), .ila_lane2_octet(ila_lane2_octet),
        .ila_lane2_active(ila_lane2_active));
    lacg_ila_rx u_lacg_ila_rx (.core_clk(core_clk), .nrst(nrst), .ila_valid(ila_valid),
        .ila_octet_num(ila_octet_num), .ila_lane1_octet(ila_lane1_octet), .ila_lane2_octet(ila_lane2_octet),
        .ila_lane2_active(ila_lane2_active), .rx_count(rx_count));
    task automatic end_sim;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask : reg_read
    function automatic logic [7:0] exp_oct(input int i, input logic lane2, input logic [7:0] c, input logic [4:0] ks);
        logic [4:0] k;
        k = c[2] ? ks : (c[3] ? 5'h10 : 5'h08);
        case (i)
            2: return {7'h00, lane2};
            3: return {c[1], 6'h00, c[3]};
            4: return {7'h00, ~c[3]};
            5: return {3'b000, k};
            7: return 8'h0d;
            8: return 8'h0f;
            13: return 8'(8'd29 + c[1] + k + lane2);
            default: return 8'h00;
        endcase
    endfunction : exp_oct
    task automatic t_after_reset;
        logic [7:0] d;
        repeat (30) @(posedge core_clk);
        `CHECK(rx_count, 8'h00)
        reg_read(ADDR_STATUS, d);
        `CHECK(d[1:0], 2'b00)
        reg_read(4'h3, d);
        `CHECK(d, 8'h00)
    endtask : t_after_reset
    // Enable must fall before a new pass is allowed
    task automatic t_pass(input logic [7:0] c, input logic [4:0] ks);
        logic [7:0] base, d;
        reg_write(ADDR_CTRL, 8'h00);
        reg_write(ADDR_KSET, {3'b000, ks});
        base = rx_count;
        reg_write(ADDR_CTRL, c | 8'h01);
        // Read back while the pass is running, so the busy flag is seen high
        reg_read(ADDR_CTRL, d);
        `CHECK(d, c | 8'h01)
        reg_read(ADDR_STATUS, d);
        `CHECK(d[2:0], 3'b101)
        reg_read(ADDR_KSET, d);
        `CHECK(d, {3'b000, ks})
        for (int n = 0; n < 40 && rx_count != 8'(base + 8'd14); n++) @(posedge core_clk);
        `CHECK(rx_count, 8'(base + 8'd14))
        for (int i = 0; i < 14; i++) begin
            `CHECK(u_lacg_ila_rx.oct1[i], exp_oct(i, 1'b0, c, ks))
            if (c[3]) `CHECK(u_lacg_ila_rx.oct2[i], exp_oct(i, 1'b1, c, ks))
        end
        reg_read(ADDR_STATUS, d);
        `CHECK(d[1:0], 2'b10)
        repeat (20) @(posedge core_clk);
        `CHECK(rx_count, 8'(base + 8'd14))
        reg_write(ADDR_STATUS, 8'h02);
        reg_read(ADDR_STATUS, d);
        `CHECK(d[1], 1'b0)
    endtask : t_pass
    task automatic t_latency(input logic twos);
        logic [13:0] w;
        reg_write(ADDR_CTRL, {3'b000, twos, 4'h0});
        repeat (25) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            @(negedge core_clk);
            w = hist[$-20];
            `CHECK(sample_out_valid, 1'b1)
            `CHECK(sample_out, {w[13] ^ twos, w[12:0]})
        end
    endtask : t_latency
    initial begin
        repeat (5000) @(posedge core_clk);
        n_fail++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_sim();
    end
    initial begin
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        t_after_reset();
        t_pass(8'h00, 5'h00);
        t_pass(8'h06, 5'h1f);
        t_pass(8'h08, 5'h00);
        t_pass(8'h0e, 5'h03);
        t_latency(1'b0);
        t_latency(1'b1);
        end_sim();
    end
endmodule : tb
`default_nettype wire
